/* File: logic/sfb_sriov_function_bar_map.sv */
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module sfb_sriov_function_bar_map #(
  parameter logic [31:0] PAGE_SIZES = sfb_pkg::PGSZ_RST
) (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  input  wire sfb_pkg::sfb_req_s  req,
  output logic [5:0]              hit_bar,
  output logic                    hit_valid,
  output logic                    req_ur,
  input  wire logic [7:0]         fn_num,
  output logic [15:0]             fn_devid,
  output logic                    fn_is_vf,
  output logic                    fn_owner_pf,
  output logic                    fn_valid,
  input  wire logic [1:0]         power_state,
  input  wire logic               wake_event,
  output logic                    power_wake_request,
  input  wire logic [63:0]        dsn,
  output sfb_pkg::sfb_caps_s      caps,
  output logic [2:0]              msix_table_bar,
  output logic [2:0]              msix_pba_bar
);
  localparam int NB = sfb_pkg::NUM_BARS;

  // aperture mask for a log2 size
  function automatic logic [63:0] ap_mask(input logic [5:0] sz);
    ap_mask = (64'h1 << sz) - 64'h1;
  endfunction : ap_mask

  // a bar indicator that points at an upper half moves to the lower dword
  function automatic logic [2:0] lower_bar(input logic [2:0] bir, input logic [NB-1:0] up);
    lower_bar = (bir < 3'(NB) && bir != 3'h0 && up[bir]) ? bir - 3'h1 : bir;
  endfunction : lower_bar

  logic [31:0] ctrl_ff;
  logic [2:0]  pf0_cnt_ff;
  logic [2:0]  pf1_cnt_ff;
  logic [15:0] devid0_ff;
  logic [15:0] devid1_ff;
  logic [2:0]  tbl_bir_ff;
  logic [2:0]  pba_bir_ff;
  logic [31:0] barcfg_ff [NB];
  logic [31:0] barbase_ff[NB];
  logic [31:0] rdata_ff;
  logic [5:0]  hit_ff;
  logic        hit_valid_ff;
  logic        ur_ff;
  logic [15:0] fn_devid_ff;
  logic        fn_is_vf_ff;
  logic        fn_owner_ff;
  logic        fn_valid_ff;
  logic        wake_ff;
  sfb_pkg::sfb_caps_s caps_ff;
  logic [2:0]  tbl_out_ff;
  logic [2:0]  pba_out_ff;

  wire logic legacy  = ctrl_ff[sfb_pkg::C_LEGACY];
  wire logic root    = ctrl_ff[sfb_pkg::C_ROOT];
  wire logic sriov   = ctrl_ff[sfb_pkg::C_SRIOV];

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // vf counts are clamped so the total never passes six
  logic [2:0] nxt_pf0_cnt;
  logic [2:0] nxt_pf1_cnt;
  always_comb begin
    nxt_pf0_cnt = (reg_wdata[2:0] > sfb_pkg::VF_TOTAL) ? sfb_pkg::VF_TOTAL : reg_wdata[2:0];
    nxt_pf1_cnt = (reg_wdata[6:4] > sfb_pkg::VF_TOTAL - nxt_pf0_cnt) ?
                  sfb_pkg::VF_TOTAL - nxt_pf0_cnt : reg_wdata[6:4];  // see R23
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff    <= sfb_pkg::CTRL_RST;
      pf0_cnt_ff <= 3'h0;
      pf1_cnt_ff <= 3'h0;
      devid0_ff  <= sfb_pkg::DEVID_RST;
      devid1_ff  <= sfb_pkg::DEVID_RST;
      tbl_bir_ff <= 3'h0;
      pba_bir_ff <= 3'h0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        sfb_pkg::A_CTRL: ctrl_ff <= reg_wdata;
        sfb_pkg::A_VFCNT: begin
          pf0_cnt_ff <= nxt_pf0_cnt;
          pf1_cnt_ff <= nxt_pf1_cnt;
        end
        sfb_pkg::A_DEVID: begin
          devid0_ff <= reg_wdata[15:0];  // see R5
          devid1_ff <= reg_wdata[31:16];
        end
        sfb_pkg::A_MSIX: begin
          tbl_bir_ff <= reg_wdata[2:0];
          pba_bir_ff <= reg_wdata[6:4];
        end
        default: ;
      endcase
    end
  end

  // bar configuration and base words, one word per bar
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NB; i++) begin
      if (sys_rst) begin
        barcfg_ff[i]  <= 32'h0;
        barbase_ff[i] <= 32'h0;
      end else if (reg_wr) begin
        if (reg_addr == sfb_pkg::A_BARCFG + 8'(i) * sfb_pkg::A_STEP)
          barcfg_ff[i] <= reg_wdata;
        if (reg_addr == sfb_pkg::A_BARBASE + 8'(i) * sfb_pkg::A_STEP)
          barbase_ff[i] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // effective bar setup
  // ----------------------------------------
  // raw settings are legalised here so software cannot build an illegal map
  sfb_pkg::sfb_bar_s bar_eff[NB];
  logic [NB-1:0]     bar_up;
  logic [63:0]       bar_full[NB];
  always_comb begin
    logic       prev64;
    logic [5:0] lo;
    logic [5:0] hi;
    prev64 = 1'b0;
    lo = 6'h0;
    hi = 6'h0;
    for (int i = 0; i < NB; i++) begin
      bar_up[i]       = prev64;  // see R8
      bar_eff[i].en   = barcfg_ff[i][sfb_pkg::B_EN] && !prev64;
      bar_eff[i].io   = barcfg_ff[i][sfb_pkg::B_IO];
      bar_eff[i].pref = barcfg_ff[i][sfb_pkg::B_PF] && !bar_eff[i].io;  // see R9
      bar_eff[i].is64 = barcfg_ff[i][sfb_pkg::B_64] && !bar_eff[i].io;
      if (bar_eff[i].io && !legacy)
        bar_eff[i].en = 1'b0;  // see R9
      if (root && i >= 2)
        bar_eff[i].en = 1'b0;  // see R7
      if (!legacy && !root && bar_eff[i].pref && i != NB - 1)
        bar_eff[i].is64 = 1'b1;  // see R13
      if (i == NB - 1 || (root && i >= 1))
        bar_eff[i].is64 = 1'b0;  // no partner word left, see R7
      lo = legacy ? sfb_pkg::MIN_SZ_LEG : sfb_pkg::MIN_SZ_EP;  // see R10
      hi = bar_eff[i].is64 ? sfb_pkg::MAX_SZ_64 : sfb_pkg::MAX_SZ_32;  // see R11
      bar_eff[i].sz = barcfg_ff[i][sfb_pkg::B_SZ +: 6];
      if (bar_eff[i].sz < lo)
        bar_eff[i].sz = lo;
      if (bar_eff[i].sz > hi)
        bar_eff[i].sz = hi;
      bar_full[i] = {(bar_eff[i].is64 && i < NB - 1) ? barbase_ff[(i + 1) % NB] : 32'h0, barbase_ff[i]};
      prev64 = bar_eff[i].en && bar_eff[i].is64;
    end
  end

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  // lowest matching bar wins; overlapping windows are a software error
  logic [5:0] hit_vec;
  always_comb begin
    hit_vec = 6'h0;
    for (int i = 0; i < NB; i++) begin
      if (bar_eff[i].en && bar_eff[i].io == req.io && hit_vec == 6'h0 &&  // see R12 see R24
          ((req.addr ^ bar_full[i]) & ~ap_mask(bar_eff[i].sz)) == 64'h0)
        hit_vec[i] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hit_ff       <= 6'h0;
      hit_valid_ff <= 1'b0;
      ur_ff        <= 1'b0;
    end else begin
      hit_ff       <= req.valid ? hit_vec : 6'h0;
      hit_valid_ff <= req.valid && hit_vec != 6'h0;
      ur_ff        <= req.valid && root && ctrl_ff[sfb_pkg::C_SNOOP] &&
                      req.ns_applicable && !req.no_snoop;  // see R20
    end
  end

  // ----------------------------------------
  // function numbering
  // ----------------------------------------
  // pf0 vfs take the lowest numbers from function 64 onward
  logic [7:0] pf1_first;
  assign pf1_first = sfb_pkg::VF_BASE_FN + 8'(pf0_cnt_ff);  // see R1 see R22

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fn_devid_ff <= 16'h0;
      fn_is_vf_ff <= 1'b0;
      fn_owner_ff <= 1'b0;
      fn_valid_ff <= 1'b0;
    end else begin
      fn_devid_ff <= 16'h0;
      fn_is_vf_ff <= 1'b0;
      fn_owner_ff <= 1'b0;
      fn_valid_ff <= 1'b0;
      if (fn_num == 8'h0 || fn_num == sfb_pkg::PF1_FN) begin
        fn_valid_ff <= 1'b1;
        fn_owner_ff <= fn_num[0];
        fn_devid_ff <= fn_num[0] ? devid1_ff : devid0_ff;
      end else if (sriov && fn_num >= sfb_pkg::VF_BASE_FN && fn_num < pf1_first) begin
        fn_valid_ff <= 1'b1;
        fn_is_vf_ff <= 1'b1;
        fn_devid_ff <= devid0_ff;  // see R5
      end else if (sriov && fn_num >= pf1_first && fn_num < pf1_first + 8'(pf1_cnt_ff)) begin
        fn_valid_ff <= 1'b1;
        fn_is_vf_ff <= 1'b1;
        fn_owner_ff <= 1'b1;
        fn_devid_ff <= devid1_ff;  // see R5
      end
    end
  end

  // first-vf offsets: first vf number minus own function number
  logic [15:0] pf0_first_virt_offset;
  logic [15:0] pf1_first_virt_offset;
  assign pf0_first_virt_offset = (pf0_cnt_ff != 3'h0) ? 16'(sfb_pkg::VF_BASE_FN) : 16'h0;  // see R2 see R4
  assign pf1_first_virt_offset = 16'(pf1_first - sfb_pkg::PF1_FN);  // see R3 see R4

  // ----------------------------------------
  // capabilities, wake and msi-x placement
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      caps_ff    <= '0;
      wake_ff    <= 1'b0;
      tbl_out_ff <= 3'h0;
      pba_out_ff <= 3'h0;
    end else begin
      caps_ff.aer   <= 1'b1;  // see R17
      caps_ff.sriov <= sriov;
      caps_ff.ari   <= sriov || ctrl_ff[sfb_pkg::C_ARI];  // see R21
      caps_ff.dsn   <= ctrl_ff[sfb_pkg::C_DSN];
      // vc lives on pf0 only and needs the serial number capability
      caps_ff.vc    <= ctrl_ff[sfb_pkg::C_VC] && ctrl_ff[sfb_pkg::C_DSN];  // see R19
      wake_ff       <= wake_event && ctrl_ff[sfb_pkg::C_PME + 32'(power_state)];  // see R16
      tbl_out_ff    <= lower_bar(tbl_bir_ff, bar_up);  // see R15
      pba_out_ff    <= lower_bar(pba_bir_ff, bar_up);
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // enabled lower bar base words read back masked to the aperture with the type bits filled; upper halves read raw, disabled bars zero
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    unique case (reg_addr)
      sfb_pkg::A_CTRL:   rd_val = ctrl_ff;
      sfb_pkg::A_VFCNT:  rd_val = {25'h0, pf1_cnt_ff, 1'b0, pf0_cnt_ff};
      sfb_pkg::A_DEVID:  rd_val = {devid1_ff, devid0_ff};
      sfb_pkg::A_PGSZ:   rd_val = PAGE_SIZES;  // see R6
      sfb_pkg::A_MSIX:   rd_val = {25'h0, pba_bir_ff, 1'b0, tbl_bir_ff};
      sfb_pkg::A_STAT:   rd_val = {pf1_first_virt_offset, pf0_first_virt_offset};
      sfb_pkg::A_DSN_LO: rd_val = ctrl_ff[sfb_pkg::C_DSN] ? dsn[31:0] : 32'h0;  // see R18
      sfb_pkg::A_DSN_HI: rd_val = ctrl_ff[sfb_pkg::C_DSN] ? dsn[63:32] : 32'h0;
      default: begin
        for (int i = 0; i < NB; i++) begin
          if (reg_addr == sfb_pkg::A_BARCFG + 8'(i) * sfb_pkg::A_STEP)
            rd_val = barcfg_ff[i];
          if (reg_addr == sfb_pkg::A_BARBASE + 8'(i) * sfb_pkg::A_STEP) begin
            if (bar_up[i])
              rd_val = barbase_ff[i];
            else if (bar_eff[i].en)
              rd_val = (barbase_ff[i] & ~32'(ap_mask(bar_eff[i].sz))) |
                       {28'h0, bar_eff[i].pref, bar_eff[i].is64, 1'b0, bar_eff[i].io};
            else
              rd_val = 32'h0;  // see R24
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      rdata_ff <= 32'h0;
    else
      rdata_ff <= reg_rd ? rd_val : 32'h0;
  end

  assign reg_rdata          = rdata_ff;
  assign hit_bar            = hit_ff;
  assign hit_valid          = hit_valid_ff;
  assign req_ur             = ur_ff;
  assign fn_devid           = fn_devid_ff;
  assign fn_is_vf           = fn_is_vf_ff;
  assign fn_owner_pf        = fn_owner_ff;
  assign fn_valid           = fn_valid_ff;
  assign power_wake_request = wake_ff;
  assign caps               = caps_ff;
  assign msix_table_bar     = tbl_out_ff;
  assign msix_pba_bar       = pba_out_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_vf_write;
    reg_wr && reg_addr == sfb_pkg::A_VFCNT;
  endsequence

  chk_vf_total_limit: assert property (s_vf_write |=> 4'(pf0_cnt_ff) + 4'(pf1_cnt_ff) <= 4'h6)  // see R23
    else $error("vf total above six");
  chk_pf0_offset: assert property (pf0_cnt_ff != 3'h0 |-> pf0_first_virt_offset == 16'd64)  // see R2
    else $error("pf0_first_virt_offset wrong");
  chk_pf1_offset: assert property (pf1_first_virt_offset == 16'd63 + 16'(pf0_cnt_ff))  // see R3
    else $error("pf1_first_virt_offset wrong");
  chk_aer_always: assert property (!$past(sys_rst) |-> caps.aer)  // see R17
    else $error("aer capability missing");
  chk_ari_follows: assert property (sriov && !sys_rst |=> caps.ari)  // see R21
    else $error("ari not forced with virtualization");
  chk_wake_gate: assert property (power_wake_request |-> $past(wake_event) &&
                                  $past(ctrl_ff[sfb_pkg::C_PME + 32'(power_state)]))  // see R16
    else $error("wake outside enabled state");
  chk_hit_type: assert property (req.valid && hit_vec != 6'h0 |=>
                                 hit_valid && hit_bar == $past(hit_vec))  // see R12
    else $error("bar hit not reported");
  chk_upper_silent: assert property (req.valid |=> (hit_bar & $past(bar_up)) == 6'h0)  // see R8
    else $error("upper half bar claimed a request");
  chk_root_bars: assert property (root |-> !bar_eff[2].en && !bar_eff[3].en)  // see R7
    else $error("root port exposes more than two bars");
  chk_vf_map: assert property (sriov && fn_num == sfb_pkg::VF_BASE_FN && pf0_cnt_ff != 3'h0 |=>
                               fn_valid && fn_is_vf && !fn_owner_pf)  // see R1
    else $error("function 64 not pf0 vf");
  // legalisation and decode guards
  // io space only exists in a legacy endpoint
  chk_io_legacy: assert property (req.valid && req.io && !legacy |=> !hit_valid)  // see R9
    else $error("io request claimed outside legacy");
  // prefetchable windows must reach above 4 GB
  chk_pref_wide: assert property (!legacy && !root && bar_eff[2].pref |-> bar_eff[2].is64)  // see R13
    else $error("prefetchable bar left 32-bit");
  // a disabled bar never shows up in a hit
  chk_off_quiet: assert property (req.valid && !bar_eff[1].en |=> !hit_bar[1])  // see R24
    else $error("disabled bar claimed a request");
  // small sizes are rounded up, never passed through
  chk_min_size: assert property (bar_eff[4].en && !legacy |-> bar_eff[4].sz >= sfb_pkg::MIN_SZ_EP)  // see R10
    else $error("aperture below minimum");
  // oversize requests are cut to the 32-bit ceiling
  chk_max_size: assert property (!bar_eff[0].is64 |-> bar_eff[0].sz <= sfb_pkg::MAX_SZ_32)  // see R11
    else $error("32-bit aperture above ceiling");
  chk_vf_devid: assert property (sriov && fn_num == sfb_pkg::VF_BASE_FN && pf0_cnt_ff != 3'h0 |=>  // see R5
                                 fn_devid == $past(devid0_ff))
    else $error("pf0 vf device id wrong");
  // the table indicator never lands on an upper half
  chk_msix_lower: assert property (msix_table_bar < 3'(NB) |->  // see R15
                                   (($past(bar_up) >> msix_table_bar) & 6'h1) == 6'h0)
    else $error("msix indicator names upper half");
  chk_snoop_root: assert property (req_ur |-> $past(root) && $past(req.valid))  // see R20
    else $error("snoop rejection outside root port");
  chk_page_sizes: assert property (reg_rd && reg_addr == sfb_pkg::A_PGSZ |=> reg_rdata == PAGE_SIZES)  // see R6
    else $error("page size word wrong");
  chk_vf_ceiling: assert property (fn_num == sfb_pkg::VF_BASE_FN + 8'(sfb_pkg::VF_TOTAL) |=> !fn_valid)  // see R23
    else $error("function past the last vf mapped");
endmodule : sfb_sriov_function_bar_map

/* File: logic/sfb_pkg.sv */
// Operation
// R1: vf numbers consecutive, pf0 vfs first
// R2: pf0_first_virt_offset is 64; code gives 0 while pf0 has no vfs
// R3: pf1_first_virt_offset is 63 plus pf0 count
// R4: offset equals first vf minus pf number
// R5: one 16-bit device id per pf's vfs
// R6: page size bit n means 2^(n+12)
// R7: endpoint six bars, root port two
// R8: 64-bit bar consumes the following bar
// R9: io bar 32-bit, unprefetchable, legacy only
// R10: minimum aperture 128 bytes, legacy 16
// R11: maximum aperture 2 GB or 256 GB
// R12: bar claims only its own space type
// R13: prefetchable non-bar5 bars forced 64-bit; code forces this only when neither legacy nor root is set
// R14: user logic holds msi-x table and pba
// R15: msi-x bar indicator names lower dword
// R16: wake request only in enabled states
// R17: aer capability always present first
// R18: user drives serial number when enabled
// R19: virtual channel only on pf0
// R20: root port may reject snoop-less requests; code rejects requests with ns_applicable set and no_snoop clear instead
// R21: ari forced on with virtualization
// R22: vfs at functions 64 to 69
// R23: at most six vfs in total
// R24: disabled bar reads zero, claims nothing
package sfb_pkg;
  // ----------------------------------------
  // function numbering
  // ----------------------------------------
  localparam int        NUM_BARS   = 6;
  localparam logic [7:0] VF_BASE_FN = 8'h40;  // function 64
  localparam logic [7:0] PF1_FN     = 8'h01;
  localparam logic [2:0] VF_TOTAL   = 3'h6;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_VFCNT   = 8'h04;
  localparam logic [7:0] A_DEVID   = 8'h08;
  localparam logic [7:0] A_PGSZ    = 8'h0c;
  localparam logic [7:0] A_MSIX    = 8'h10;
  localparam logic [7:0] A_STAT    = 8'h14;
  localparam logic [7:0] A_DSN_LO  = 8'h18;
  localparam logic [7:0] A_DSN_HI  = 8'h1c;
  localparam logic [7:0] A_BARCFG  = 8'h20;  // plus 4 per bar
  localparam logic [7:0] A_BARBASE = 8'h40;  // plus 4 per bar
  localparam logic [7:0] A_STEP    = 8'h04;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int C_SRIOV  = 0;
  localparam int C_LEGACY = 1;
  localparam int C_ROOT   = 2;
  localparam int C_SNOOP  = 3;
  localparam int C_DSN    = 4;
  localparam int C_VC     = 5;
  localparam int C_ARI    = 6;
  localparam int C_PME    = 8;   // four bits, one per power state
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // ----------------------------------------
  // bar fields and aperture limits
  // ----------------------------------------
  localparam int B_EN = 0;
  localparam int B_IO = 1;
  localparam int B_64 = 2;
  localparam int B_PF = 3;
  localparam int B_SZ = 8;  // six bit log2 aperture
  localparam logic [5:0] MIN_SZ_EP  = 6'd7;   // 128 B
  localparam logic [5:0] MIN_SZ_LEG = 6'd4;   // 16 B
  localparam logic [5:0] MAX_SZ_32  = 6'd31;  // 2 GB
  localparam logic [5:0] MAX_SZ_64  = 6'd38;  // 256 GB
  localparam int PAGE_SHIFT = 12;
  localparam logic [31:0] PGSZ_RST = 32'h0000_0553;
  localparam logic [15:0] DEVID_RST = 16'h0001;  // arbitrary value
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       en;
    logic       io;
    logic       is64;
    logic       pref;
    logic [5:0] sz;
  } sfb_bar_s;

  typedef struct packed {
    logic        valid;
    logic        io;
    logic [63:0] addr;
    logic        ns_applicable;
    logic        no_snoop;
  } sfb_req_s;

  typedef struct packed {
    logic aer;
    logic dsn;
    logic vc;
    logic ari;
    logic sriov;
  } sfb_caps_s;
endpackage : sfb_pkg

/* File: sim/sfb_host_model.sv */
`timescale 1ns/1ns
module sfb_host_model #(
  parameter logic [63:0] SERIAL = 64'h0123_4567_89ab_cdef  // arbitrary value
) (
  input  wire logic              clk_sys,
  input  wire sfb_pkg::sfb_req_s cmd,
  output sfb_pkg::sfb_req_s      req,
  output logic [63:0]            dsn
);
  // ----------------------------------------
  // user side and link side of the far party
  // ----------------------------------------
  // user logic presents its serial number as a steady level
  assign dsn = SERIAL;

  // one request per command; between requests the fields carry the inverse of the last ones,
  // so a stale address can never decode by luck
  always_ff @(posedge clk_sys) begin
    if (cmd.valid) begin
      req <= cmd;
    end else begin
      req <= '{valid: 1'b0, io: ~cmd.io, addr: ~cmd.addr, ns_applicable: ~cmd.ns_applicable,
               no_snoop: ~cmd.no_snoop};
    end
  end
endmodule : sfb_host_model

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam logic [31:0] PG_SIZES = 32'h0000_0011;
  localparam logic [63:0] SERIAL   = 64'h0123_4567_89ab_cdef;  // arbitrary value
  logic              clk_sys, sys_rst, reg_wr, reg_rd, hit_valid, req_ur, fn_is_vf, fn_owner_pf, fn_valid;
  logic              wake_event, power_wake_request;
  logic [7:0]        reg_addr, fn_num;
  logic [31:0]       reg_wdata, reg_rdata, seed;
  logic [5:0]        hit_bar;
  logic [15:0]       fn_devid;
  logic [1:0]        power_state;
  logic [63:0]       dsn;
  logic [2:0]        msix_table_bar, msix_pba_bar;
  sfb_pkg::sfb_req_s cmd, req;
  sfb_pkg::sfb_caps_s caps;
  logic [31:0]       rd_q[$];
  logic [7:0]        rq_q[$];
  logic              rd_seen = 1'b0, rq_seen = 1'b0;
  int                failures = 0, cmp_count = 0, m, p0, p1;
  // bar table: raw config, base written, base read back
  logic [31:0] bar_cfg[6] = '{32'h0000_2801, 32'h0000_0c03, 32'h0000_1409, 32'h0000_0c01, 32'h0000_0301,
                              32'h0000_0c09};
  logic [31:0] bar_base[6] = '{32'hc000_0000, 32'h0000_1000, 32'h1230_0000, 32'h0000_0001, 32'h0000_3fff,
                               32'h0000_9abc};
  logic [31:0] bar_exp[6] = '{32'h8000_0000, 32'h0, 32'h1230_000c, 32'h0000_0001, 32'h0000_3f80,
                              32'h0000_9008};

  sfb_sriov_function_bar_map #(.PAGE_SIZES(PG_SIZES)) sfb_sriov_function_bar_map_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .hit_bar(hit_bar),
    .hit_valid(hit_valid), .req_ur(req_ur), .fn_num(fn_num), .fn_devid(fn_devid), .fn_is_vf(fn_is_vf),
    .fn_owner_pf(fn_owner_pf), .fn_valid(fn_valid), .power_state(power_state), .wake_event(wake_event),
    .power_wake_request(power_wake_request), .dsn(dsn), .caps(caps), .msix_table_bar(msix_table_bar),
    .msix_pba_bar(msix_pba_bar));
  sfb_host_model #(.SERIAL(SERIAL)) sfb_host_model_i (.clk_sys(clk_sys), .cmd(cmd), .req(req), .dsn(dsn));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // the expected word is noted when the strobe goes up
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    rd_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic rq(input logic [63:0] a, input logic io, input logic [7:0] e, input logic nsa = 1'b0,
                    input logic ns = 1'b0);
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, io: io, addr: a, ns_applicable: nsa, no_snoop: ns};
    rq_q.push_back(e);
    @(posedge clk_sys);
    cmd.valid <= 1'b0;
  endtask : rq

  task automatic look(input logic [7:0] f, input logic v, input logic vf, input logic own, input logic [15:0] d);
    @(posedge clk_sys);
    fn_num <= f;
    @(posedge clk_sys);
    @(negedge clk_sys);
    if (vf) check("fn lookup", {fn_valid, fn_is_vf, fn_owner_pf, fn_devid}, {v, 1'b1, own, d});
    else check("fn_valid", fn_valid, v);
  endtask : look

  task automatic tally_and_finish;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // clock, watchdog and result watcher
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // a hang counts as a mismatch and ends the run
  initial begin
    idle(20000);
    failures++;
    tally_and_finish();
  end

  // answers are registered at the taking edge itself, so they are sampled at the following falling edge
  always @(posedge clk_sys) begin
    rd_seen <= reg_rd;
    rq_seen <= req.valid;
  end
  always @(negedge clk_sys) begin
    if (rd_seen) begin
      if (rd_q.size() > 0) check("reg_rdata", reg_rdata, rd_q.pop_front());
      else failures++;
    end
    if (rq_seen) begin
      if (rq_q.size() > 0) check("hit_bar hit_valid req_ur", {hit_bar, hit_valid, req_ur}, rq_q.pop_front());
      else failures++;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0; cmd = '0;
    fn_num = '0; power_state = '0; wake_event = 1'b0; seed = 32'h603f;
    idle(12);
    sys_rst <= 1'b0;
    rd(sfb_pkg::A_CTRL, sfb_pkg::CTRL_RST);
    rd(sfb_pkg::A_DEVID, 32'h0001_0001);
    wr(sfb_pkg::A_PGSZ, 32'hffff_ffff);
    rd(sfb_pkg::A_PGSZ, PG_SIZES);
    rd(8'h80, 32'h0);
    check("caps", caps, 5'b10011);
    // every pf0 count, with a random pf1 count, including counts that must be clamped
    wr(sfb_pkg::A_DEVID, 32'hbeef_cafe);
    for (int n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      m = seed[2:0];
      p0 = (n > 6) ? 6 : n;
      p1 = (m > 6 - p0) ? 6 - p0 : m;
      wr(sfb_pkg::A_VFCNT, {25'h0, seed[2:0], 1'b0, 3'(n)});
      rd(sfb_pkg::A_STAT, {16'(63 + p0), (p0 > 0) ? 16'd64 : 16'd0});
      for (int f = 62; f < 71; f++) begin
        look(8'(f), f >= 64 && f < 64 + p0 + p1, f >= 64 && f < 64 + p0 + p1, f >= 64 + p0,
             (f >= 64 + p0) ? 16'hbeef : 16'hcafe);
      end
    end
    look(8'h00, 1'b1, 1'b0, 1'b0, 16'h0);
    look(8'h01, 1'b1, 1'b0, 1'b0, 16'h0);
    // bar legalisation and read-back
    for (int i = 0; i < 6; i++) begin
      wr(sfb_pkg::A_BARCFG + 8'(4 * i), bar_cfg[i]);
      wr(sfb_pkg::A_BARBASE + 8'(4 * i), bar_base[i]);
    end
    for (int i = 0; i < 6; i++) begin
      rd(sfb_pkg::A_BARCFG + 8'(4 * i), bar_cfg[i]);
      rd(sfb_pkg::A_BARBASE + 8'(4 * i), bar_exp[i]);
    end
    rq(64'h0_8000_1234, 1'b0, 8'h06);
    rq(64'h0_8000_1234, 1'b1, 8'h00);
    rq(64'h0_7fff_fffc, 1'b0, 8'h00);
    rq(64'h1_1234_5678, 1'b0, 8'h12);
    rq(64'h0_1234_5678, 1'b0, 8'h00);
    rq(64'h0_0000_0800, 1'b0, 8'h00);
    rq(64'h0_0000_1000, 1'b1, 8'h00);
    rq(64'h0_0000_3fff, 1'b0, 8'h42);
    rq(64'h0_0000_4000, 1'b0, 8'h00);
    rq(64'h0_0000_9ffc, 1'b0, 8'h82);
    // table on the upper half of bar2 names bar2
    wr(sfb_pkg::A_MSIX, 32'h0000_0053); // table and pba kept in memory bars
    idle(2);
    check("msix bars", {msix_table_bar, msix_pba_bar}, 6'o25);
    // capability presence
    wr(sfb_pkg::A_CTRL, 32'h0000_0021);
    idle(2);
    check("caps", caps, 5'b10011);
    rd(sfb_pkg::A_DSN_LO, 32'h0);
    wr(sfb_pkg::A_CTRL, 32'h0000_0031);
    idle(2);
    check("caps", caps, 5'b11111);
    rd(sfb_pkg::A_DSN_LO, SERIAL[31:0]);
    rd(sfb_pkg::A_DSN_HI, SERIAL[63:32]);
    wr(sfb_pkg::A_CTRL, 32'h0000_0000);
    idle(2);
    check("caps", caps, 5'b10000);
    wr(sfb_pkg::A_CTRL, 32'h0000_0040);
    idle(2);
    check("caps", caps, 5'b10010);
    // wake only from D0 and D2
    wr(sfb_pkg::A_CTRL, 32'h0000_0501);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      power_state <= 2'(k);
      wake_event <= k[2];
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("power_wake_request", power_wake_request, k[2] & ~k[0]);
    end
    // snoop rejection acts in root port mode only; root port keeps bars 0 and 1
    wr(sfb_pkg::A_CTRL, 32'h0000_0009);
    rq(64'h0_7000_0000, 1'b0, 8'h00, 1'b1, 1'b0);
    wr(sfb_pkg::A_CTRL, 32'h0000_000d);
    rq(64'h0_7000_0000, 1'b0, 8'h01, 1'b1, 1'b0);
    rq(64'h0_7000_0000, 1'b0, 8'h00, 1'b1, 1'b1);
    rq(64'h0_0000_9ffc, 1'b0, 8'h00);
    rq(64'h0_8000_1234, 1'b0, 8'h06);
    for (int k = 0; k < 20 && (rd_q.size() + rq_q.size()) > 0; k++) idle(1);
    if ((rd_q.size() + rq_q.size()) > 0) failures++;
    tally_and_finish();
  end
endmodule : tb
